// ---- crsq_pkg.sv ----
package crsq_pkg;

  // Register byte offsets on the APB slave
  localparam logic [7:0] MAIN_CLOCK_CONTROL_ADDR = 8'h00;
  localparam logic [7:0] RC_TRIM_CONTROL_ADDR    = 8'h04;
  localparam logic [7:0] SYS_INTEGRITY_ADDR      = 8'h08;
  localparam logic [7:0] FACTORY_TRIM_ADDR       = 8'h0C;

  // Field positions and reset values
  localparam int         SLOW_MODE_BIT           = 0;
  localparam int         CLOCK_OUT_BIT           = 1;
  localparam int         LOCKED_BIT              = 3;
  localparam logic [1:0] MAIN_CLOCK_RESET        = 2'h0;
  localparam logic [7:0] TRIM_RESET              = 8'hFF;

  // Factory calibration bytes and their memory locations (values arbitrary)
  localparam logic [15:0] FACTORY_TRIM_5V_LOC    = 16'hFFDE;
  localparam logic [15:0] FACTORY_TRIM_3V_LOC    = 16'hFFDF;
  localparam logic [7:0]  FACTORY_TRIM_5V        = 8'h80;
  localparam logic [7:0]  FACTORY_TRIM_3V        = 8'h90;

  // Reset vector location
  localparam logic [14:0] RESET_VECTOR_BASE      = 15'h7FFF;

  // Clock source select codes
  localparam logic [1:0] SRC_EXTERNAL            = 2'h0;
  localparam logic [1:0] SRC_RC                  = 2'h1;
  localparam logic [1:0] SRC_MULTIPLIER          = 2'h2;

  // Timing
  localparam int         CLK_PERIOD_NS           = 4;
  localparam int         STARTUP_NS              = 2000;
  localparam int         RESET_OUT_MIN_NS        = 200;
  localparam logic [9:0] STARTUP_CYCLES          =
    10'((STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] RESET_OUT_MIN_CYCLES    =
    8'((RESET_OUT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [11:0] DELAY_SHORT_LAST       = 12'h0FF;
  localparam logic [11:0] DELAY_LONG_LAST        = 12'hFFF;
  localparam logic [4:0]  SLOW_DIV_LAST          = 5'h1F;

  typedef enum logic [4:0] {
    PH_ACTIVE    = 5'h01,
    PH_LOCK_WAIT = 5'h02,
    PH_DELAY     = 5'h04,
    PH_FETCH     = 5'h08,
    PH_RUN       = 5'h10
  } crsq_phase_type;

endpackage

// ---- crsq_sequencer.sv ----
// Function
// - Every reset returns the trim register to FFh.
// - Factory trim bytes for 5 V and 3 V held at fixed locations.
// - Trim code 00h is fastest, FFh slowest, monotonic between.
// - Multiplier times 4 or 8, enabled and set by two option bits.
// - No multiplier: RC gives 1 MHz, else external clock input.
// - Multiplier output withheld until start-up delay after reset or wakeup.
// - Lock flag set when multiplier reaches operating frequency.
// - Control bit 1 enables clock output pin; reset clears it.
// - Control bit 0 selects CPU clock divided by 32; reset clears it.
// - Reset from pin, low voltage, watchdog or illegal opcode.
// - Reset pin driven low throughout the delay phase.
// - Delay is 256 CPU cycles, or 4096 with a resonator.
// - Vector fetch from FFFE-FFFF takes exactly two cycles.
// - Multiplier start-up delay added before clocking resumes.
// - External low pulse meets minimum width; device enters reset.
// - Resonator keeps running during reset.
// - Timer multiplier needs 8 MHz: RC times 8 or 16 MHz halved.
// - Without multi-oscillator, external clock comes from port pin.
// - Lock flag is bit 3 of integrity status, hardware only.
// - Watchdog reset pulls reset pin low for minimum pulse width.
//
// Local design decisions: the address map and the APB slave port.
module crsq_sequencer (
  input  wire logic        mclk_in,
  input  wire logic        reset_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        multiplier_enable_in,
  input  wire logic        multiplier_x8_in,
  input  wire logic        rc_osc_enable_in,
  input  wire logic        resonator_select_in,
  input  wire logic        multi_osc_used_in,
  input  wire logic        ext_clock_16mhz_in,
  input  wire logic        oscillator_tick_in,
  input  wire logic        wakeup_in,
  input  wire logic        reset_pin_in,
  input  wire logic        low_voltage_reset_in,
  input  wire logic        watchdog_reset_in,
  input  wire logic        illegal_opcode_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_out,
  output logic             cpu_reset_out,
  output logic             cpu_tick_out,
  output logic             vector_fetch_out,
  output logic      [15:0] vector_addr_out,
  output logic      [7:0]  trim_code_out,
  output logic      [1:0]  osc_source_out,
  output logic             multiplier_x8_out,
  output logic             multiplier_locked_out,
  output logic             clock_out_pin_out,
  output logic             clock_out_enable_out,
  output logic             resonator_run_out,
  output logic             ext_clock_on_port_pin_out,
  output logic             timer_clock_ok_out,
  output logic             timer_input_div2_out
);

  typedef struct packed {
    crsq_pkg::crsq_phase_type phase;
    logic [7:0]               active_count;
    logic [11:0]              delay_count;
    logic                     fetch_count;
    logic [9:0]               startup_count;
    logic                     locked;
    logic [1:0]               main_ctrl;
    logic [7:0]               trim;
    logic [4:0]               slow_count;
    logic                     cpu_tick;
    logic                     clk_out;
    logic [1:0]               src_sel;
    logic                     mult_x8;
    logic                     resonator_run;
    logic                     port_pin_clk;
    logic                     timer_ok;
    logic                     timer_div2;
    logic [31:0]              rdata;
  } crsq_state_type;

  crsq_state_type st;
  crsq_state_type next_st;

  logic        src_any;
  logic        gated_tick;
  logic        wr_access;
  logic        rd_setup;
  logic        addr_hit;
  logic [11:0] delay_last;

  // Pin low counts as external only while the sequencer is not pulling it itself
  assign src_any    = (!reset_pin_in && !reset_pin_oe_out) || low_voltage_reset_in
                      || watchdog_reset_in || illegal_opcode_in;
  assign gated_tick = oscillator_tick_in && (!multiplier_enable_in || st.locked);
  assign wr_access  = psel_in && penable_in && pwrite_in;
  assign rd_setup   = psel_in && !penable_in && !pwrite_in;
  assign addr_hit   = (paddr_in == crsq_pkg::MAIN_CLOCK_CONTROL_ADDR)
                      || (paddr_in == crsq_pkg::RC_TRIM_CONTROL_ADDR)
                      || (paddr_in == crsq_pkg::SYS_INTEGRITY_ADDR)
                      || (paddr_in == crsq_pkg::FACTORY_TRIM_ADDR);
  assign delay_last = resonator_select_in ? crsq_pkg::DELAY_LONG_LAST
                                          : crsq_pkg::DELAY_SHORT_LAST;

  always_comb begin
    next_st = st;
    // Oscillator source and option decode
    if (multiplier_enable_in) begin
      next_st.src_sel = crsq_pkg::SRC_MULTIPLIER;
    end else if (rc_osc_enable_in) begin
      next_st.src_sel = crsq_pkg::SRC_RC;
    end else begin
      next_st.src_sel = crsq_pkg::SRC_EXTERNAL;
    end
    next_st.mult_x8       = multiplier_x8_in;
    next_st.resonator_run = resonator_select_in;
    next_st.port_pin_clk  = !multi_osc_used_in;
    next_st.timer_ok      = (rc_osc_enable_in && multiplier_enable_in && multiplier_x8_in)
                            || ext_clock_16mhz_in;
    next_st.timer_div2    = ext_clock_16mhz_in;
    // Multiplier start-up and lock
    if (multiplier_enable_in && !st.locked) begin
      if (st.startup_count == crsq_pkg::STARTUP_CYCLES - 10'h001) begin
        next_st.locked = 1'b1;
      end else begin
        next_st.startup_count = st.startup_count + 10'h001;
      end
    end
    if (!multiplier_enable_in || wakeup_in) begin
      next_st.locked        = 1'b0;
      next_st.startup_count = 10'h000;
    end
    // CPU clock: oscillator tick, or one in 32 in slow mode
    next_st.cpu_tick = 1'b0;
    if (gated_tick) begin
      if (st.main_ctrl[crsq_pkg::SLOW_MODE_BIT]) begin
        next_st.slow_count = st.slow_count + 5'h01;
        next_st.cpu_tick   = (st.slow_count == crsq_pkg::SLOW_DIV_LAST);
      end else begin
        next_st.slow_count = 5'h00;
        next_st.cpu_tick   = 1'b1;
      end
    end
    next_st.clk_out = st.main_ctrl[crsq_pkg::CLOCK_OUT_BIT] && gated_tick;
    // Register writes
    if (wr_access && paddr_in == crsq_pkg::MAIN_CLOCK_CONTROL_ADDR) begin
      next_st.main_ctrl = pwdata_in[1:0];
    end
    if (wr_access && paddr_in == crsq_pkg::RC_TRIM_CONTROL_ADDR) begin
      next_st.trim = pwdata_in[7:0];
    end
    // Read data prepared in the setup cycle
    if (rd_setup) begin
      next_st.rdata = 32'h0000_0000;
      unique case (paddr_in)
        crsq_pkg::MAIN_CLOCK_CONTROL_ADDR: next_st.rdata[1:0] = st.main_ctrl;
        crsq_pkg::RC_TRIM_CONTROL_ADDR:    next_st.rdata[7:0] = st.trim;
        crsq_pkg::SYS_INTEGRITY_ADDR: begin
          next_st.rdata[crsq_pkg::LOCKED_BIT] = st.locked;
        end
        crsq_pkg::FACTORY_TRIM_ADDR: begin
          next_st.rdata[15:0] = {crsq_pkg::FACTORY_TRIM_3V, crsq_pkg::FACTORY_TRIM_5V};
        end
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    // Reset sequence
    unique case (st.phase)
      crsq_pkg::PH_ACTIVE: begin
        if (st.active_count != crsq_pkg::RESET_OUT_MIN_CYCLES) begin
          next_st.active_count = st.active_count + 8'h01;
        end else begin
          next_st.delay_count = 12'h000;
          next_st.phase = multiplier_enable_in ? crsq_pkg::PH_LOCK_WAIT
                                               : crsq_pkg::PH_DELAY;
        end
      end
      crsq_pkg::PH_LOCK_WAIT: begin
        if (st.locked) begin
          next_st.phase = crsq_pkg::PH_DELAY;
        end
      end
      crsq_pkg::PH_DELAY: begin
        if (st.cpu_tick) begin
          if (st.delay_count == delay_last) begin
            next_st.phase       = crsq_pkg::PH_FETCH;
            next_st.fetch_count = 1'b0;
          end else begin
            next_st.delay_count = st.delay_count + 12'h001;
          end
        end
      end
      crsq_pkg::PH_FETCH: begin
        next_st.fetch_count = 1'b1;
        if (st.fetch_count) begin
          next_st.phase = crsq_pkg::PH_RUN;
        end
      end
      crsq_pkg::PH_RUN: begin
        next_st.phase = crsq_pkg::PH_RUN;
      end
      default: next_st.phase = crsq_pkg::PH_ACTIVE;
    endcase
    // Any reset source restarts the sequence and clears control state
    if (src_any) begin
      next_st.phase         = crsq_pkg::PH_ACTIVE;
      next_st.active_count  = 8'h00;
      next_st.delay_count   = 12'h000;
      next_st.fetch_count   = 1'b0;
      next_st.trim          = crsq_pkg::TRIM_RESET;
      next_st.main_ctrl     = crsq_pkg::MAIN_CLOCK_RESET;
      next_st.locked        = 1'b0;
      next_st.startup_count = 10'h000;
      next_st.slow_count    = 5'h00;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st               <= '0;
      st.phase         <= crsq_pkg::PH_ACTIVE;
      st.trim          <= crsq_pkg::TRIM_RESET;
      st.main_ctrl     <= crsq_pkg::MAIN_CLOCK_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata_out                = st.rdata;
  assign pready_out                = 1'b1;
  assign pslverr_out               = psel_in && penable_in && !addr_hit;
  assign reset_pin_out             = 1'b0;
  assign reset_pin_oe_out          = st.phase != crsq_pkg::PH_FETCH
                                     && st.phase != crsq_pkg::PH_RUN;
  assign cpu_reset_out             = st.phase != crsq_pkg::PH_RUN;
  assign cpu_tick_out              = st.cpu_tick;
  assign vector_fetch_out          = st.phase == crsq_pkg::PH_FETCH;
  assign vector_addr_out           = {crsq_pkg::RESET_VECTOR_BASE, st.fetch_count};
  assign trim_code_out             = st.trim;
  assign osc_source_out            = st.src_sel;
  assign multiplier_x8_out         = st.mult_x8;
  assign multiplier_locked_out     = st.locked;
  assign clock_out_pin_out         = st.clk_out;
  assign clock_out_enable_out      = st.main_ctrl[crsq_pkg::CLOCK_OUT_BIT];
  assign resonator_run_out         = st.resonator_run;
  assign ext_clock_on_port_pin_out = st.port_pin_clk;
  assign timer_clock_ok_out        = st.timer_ok;
  assign timer_input_div2_out      = st.timer_div2;

  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  property p_trim_reset;
    src_any |=> trim_code_out == 8'hFF;
  endproperty
  a_trim_reset: assert property (p_trim_reset) else $error("trim not FFh after reset");

  property p_trim_write;
    (wr_access && paddr_in == crsq_pkg::RC_TRIM_CONTROL_ADDR && !src_any)
      |=> trim_code_out == $past(pwdata_in[7:0]);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write not applied");

  property p_mult_gate;
    (multiplier_enable_in && !st.locked) |=> !cpu_tick_out;
  endproperty
  a_mult_gate: assert property (p_mult_gate) else $error("clock before multiplier lock");

  property p_normal_tick;
    (gated_tick && !st.main_ctrl[0]) |=> cpu_tick_out;
  endproperty
  a_normal_tick: assert property (p_normal_tick) else $error("normal mode tick missing");

  property p_pin_low;
    st.phase == crsq_pkg::PH_DELAY |-> reset_pin_oe_out && !reset_pin_out;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("reset pin released in delay");

  property p_delay_release;
    (st.phase == crsq_pkg::PH_DELAY && st.cpu_tick && st.delay_count == delay_last && !src_any)
      |=> vector_fetch_out && !reset_pin_oe_out && vector_addr_out == 16'hFFFE;
  endproperty
  a_delay_release: assert property (p_delay_release) else $error("delay end wrong");

  property p_fetch_two;
    (vector_fetch_out && !st.fetch_count && !src_any) ##1 !src_any
      |-> vector_fetch_out && vector_addr_out == 16'hFFFF ##1 !cpu_reset_out;
  endproperty
  a_fetch_two: assert property (p_fetch_two) else $error("fetch not two cycles");

  property p_lock_wait;
    (st.phase == crsq_pkg::PH_LOCK_WAIT && !st.locked && !src_any)
      |=> st.phase != crsq_pkg::PH_DELAY;
  endproperty
  a_lock_wait: assert property (p_lock_wait) else $error("delay began before lock");

  property p_source_reset;
    src_any |=> cpu_reset_out && reset_pin_oe_out && !clock_out_enable_out;
  endproperty
  a_source_reset: assert property (p_source_reset) else $error("reset source ignored");

  property p_wdg_pulse;
    watchdog_reset_in |=> reset_pin_oe_out [*8];
  endproperty
  a_wdg_pulse: assert property (p_wdg_pulse) else $error("watchdog pulse too short");

  property p_lock_read;
    (rd_setup && paddr_in == crsq_pkg::SYS_INTEGRITY_ADDR)
      |=> prdata_out[3] == $past(st.locked);
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock flag read wrong");

  property p_run_reached;
    st.phase == crsq_pkg::PH_FETCH ##1 st.phase == crsq_pkg::PH_RUN;
  endproperty
  c_run_reached: cover property (p_run_reached);

  property p_locked_seen;
    $rose(st.locked);
  endproperty
  c_locked_seen: cover property (p_locked_seen);

  property p_slow_tick;
    st.main_ctrl[0] && cpu_tick_out;
  endproperty
  c_slow_tick: cover property (p_slow_tick);

endmodule

// ---- crsq_partner.sv ----
module crsq_partner #(
  parameter int HOLD_CYCLES = 8
) (
  input  wire logic       mclk_in,
  input  wire logic       reset_n_in,
  input  wire logic [7:0] tick_period_in,
  input  wire logic       pulse_req_in,
  input  wire logic       reset_pin_oe_in,
  output logic            oscillator_tick_out,
  output logic            reset_pin_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tick_cnt = 8'h00;
  logic [7:0] hold_cnt;
  // Source clock keeps ticking through every reset phase
  always @(posedge mclk_in) begin
    tick_cnt <= (tick_cnt + 8'h01 >= tick_period_in) ? 8'h00 : tick_cnt + 8'h01;
  end
  assign oscillator_tick_out = (tick_cnt == 8'h00);
  // External reset circuit holds the pin low for HOLD_CYCLES (8) cycles per request
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hold_cnt <= 8'h00;
    end else if (pulse_req_in) begin
      hold_cnt <= 8'(HOLD_CYCLES);
    end else if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end
  end
  // Pull-up gives high when nobody pulls the open-drain pin low
  assign reset_pin_level_out = !(reset_pin_oe_in || hold_cnt != 8'h00);
endmodule

// ---- clock_and_reset_sequencer_test.sv ----
module clock_and_reset_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        opt_mul = 1'b0, opt_x8 = 1'b0, opt_rc = 1'b1, opt_res = 1'b0;
  logic        opt_mo = 1'b1, opt_16 = 1'b0, wake = 1'b0, lvr = 1'b0, wdr = 1'b0;
  logic        illop = 1'b0, ext_pulse = 1'b0, tick, pin_level, pready, pslverr, er;
  logic        pin_oe, cpu_rst, cpu_tick, vfetch, x8_o, locked, clk_pin, clk_en;
  logic        res_run, port_pin, tmr_ok, tmr_div2, gap, pin_drv;
  logic [15:0] vaddr;
  logic [7:0]  trim;
  logic [1:0]  osrc;
  int          err_count = 0, compares = 0, n_s, n_l, n_m, n, t, p;

  always #2 clk = ~clk;

  crsq_partner part_u (.mclk_in(clk), .reset_n_in(rst_n), .tick_period_in(8'h01),
    .pulse_req_in(ext_pulse), .reset_pin_oe_in(pin_oe), .oscillator_tick_out(tick),
    .reset_pin_level_out(pin_level));

  crsq_sequencer dut_u (.mclk_in(clk), .reset_n_in(rst_n), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .multiplier_enable_in(opt_mul), .multiplier_x8_in(opt_x8), .rc_osc_enable_in(opt_rc),
    .resonator_select_in(opt_res), .multi_osc_used_in(opt_mo), .ext_clock_16mhz_in(opt_16),
    .oscillator_tick_in(tick), .wakeup_in(wake), .reset_pin_in(pin_level),
    .low_voltage_reset_in(lvr), .watchdog_reset_in(wdr), .illegal_opcode_in(illop),
    .reset_pin_out(pin_drv), .reset_pin_oe_out(pin_oe), .cpu_reset_out(cpu_rst),
    .cpu_tick_out(cpu_tick), .vector_fetch_out(vfetch), .vector_addr_out(vaddr),
    .trim_code_out(trim), .osc_source_out(osrc), .multiplier_x8_out(x8_o),
    .multiplier_locked_out(locked), .clock_out_pin_out(clk_pin),
    .clock_out_enable_out(clk_en), .resonator_run_out(res_run),
    .ext_clock_on_port_pin_out(port_pin), .timer_clock_ok_out(tmr_ok),
    .timer_input_div2_out(tmr_div2));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_run(output int cnt);
    cnt = 0;
    gap = 1'b0;
    while (vfetch !== 1'b1 && cnt < 20000) begin
      @(posedge clk);
      cnt++;
      if (cnt > 3 && vfetch !== 1'b1 && pin_oe !== 1'b1) gap = 1'b1;
    end
    chk("pin low gap", {31'h0, gap}, 32'h0);
    chk("vector first", {16'h0, vaddr}, 32'h0000FFFE);
    @(posedge clk);
    chk("fetch second", {15'h0, vfetch, vaddr}, 32'h0001FFFF);
    @(posedge clk);
    chk("run state", {30'h0, vfetch, cpu_rst}, 32'h0);
    chk("pin released", {31'h0, pin_oe}, 32'h0);
  endtask

  task automatic src_seq(input int s, output int cnt);
    @(posedge clk);
    case (s)
      0: lvr <= 1'b1;
      1: wdr <= 1'b1;
      2: illop <= 1'b1;
      default: ext_pulse <= 1'b1;
    endcase
    @(posedge clk);
    {lvr, wdr, illop, ext_pulse} <= 4'h0;
    repeat (4) @(posedge clk);
    chk("reset entered", {29'h0, pin_drv, cpu_rst, pin_oe}, 32'h3);
    wait_run(cnt);
  endtask

  task automatic count(input int cyc);
    t = 0;
    p = 0;
    repeat (cyc) begin
      @(posedge clk);
      t += int'(cpu_tick === 1'b1);
      p += int'(clk_pin === 1'b1);
    end
  endtask

  task automatic t_regs;
    apb(1'b0, crsq_pkg::MAIN_CLOCK_CONTROL_ADDR, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'b0, crsq_pkg::RC_TRIM_CONTROL_ADDR, 32'h0);
    chk("trim reset", rd, 32'hFF);
    apb(1'b0, crsq_pkg::FACTORY_TRIM_ADDR, 32'h0);
    chk("factory trims", rd, 32'h9080);
    apb(1'b0, crsq_pkg::SYS_INTEGRITY_ADDR, 32'h0);
    chk("unlocked", rd & 32'h8, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", {rd[30:0], er}, 32'h1);
    apb(1'b1, crsq_pkg::RC_TRIM_CONTROL_ADDR, 32'h80);
    @(posedge clk);
    #1 chk("trim out", {24'h0, trim}, 32'h80);
    apb(1'b1, crsq_pkg::MAIN_CLOCK_CONTROL_ADDR, 32'h3);
    apb(1'b0, crsq_pkg::MAIN_CLOCK_CONTROL_ADDR, 32'h0);
    chk("ctrl back", rd, 32'h3);
    chk("clock out en", {31'h0, clk_en}, 32'h1);
  endtask

  task automatic t_slow;
    count(640);
    chk("slow ticks", {31'h0, t >= 19 && t <= 21}, 32'h1);
    chk("clock out on", {31'h0, p > 0}, 32'h1);
    apb(1'b1, crsq_pkg::MAIN_CLOCK_CONTROL_ADDR, 32'h0);
    @(posedge clk);
    count(640);
    chk("fast ticks", t, 640);
    chk("clock out off", p, 32'h0);
  endtask

  task automatic t_sources;
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, crsq_pkg::RC_TRIM_CONTROL_ADDR, 32'h55);
      apb(1'b1, crsq_pkg::MAIN_CLOCK_CONTROL_ADDR, 32'h3);
      src_seq(s, n);
      if (s == 1) n_s = n;
      #1 chk("trim after src", {24'h0, trim}, 32'hFF);
      chk("ctrl after src", {31'h0, clk_en}, 32'h0);
    end
    @(posedge clk);
    opt_res <= 1'b1;
    src_seq(1, n_l);
    chk("long delay", n_l - n_s, 3840);
    chk("resonator run", {31'h0, res_run}, 32'h1);
    chk("short delay", {31'h0, n_s >= 256 && n_s <= 320}, 32'h1);
  endtask

  task automatic t_opts;
    opt_res <= 1'b0;
    opt_mo <= 1'b0;
    repeat (3) @(posedge clk);
    chk("rc source", {30'h0, osrc}, {30'h0, crsq_pkg::SRC_RC});
    chk("port pin", {30'h0, port_pin, tmr_ok}, 32'h2);
    opt_rc <= 1'b0;
    opt_16 <= 1'b1;
    repeat (3) @(posedge clk);
    chk("ext source", {30'h0, osrc}, {30'h0, crsq_pkg::SRC_EXTERNAL});
    chk("timer halved", {30'h0, tmr_div2, tmr_ok}, 32'h3);
    {opt_16, opt_rc, opt_mo, opt_mul, opt_x8} <= 5'h1F;
    src_seq(1, n_m);
    // Source was raised five edges before wait_run starts counting
    n = n_m + 5 - int'(crsq_pkg::STARTUP_CYCLES);
    chk("startup added", {31'h0, n >= 256 && n <= 264}, 32'h1);
    apb(1'b0, crsq_pkg::SYS_INTEGRITY_ADDR, 32'h0);
    chk("locked", rd & 32'h8, 32'h8);
    chk("mult source", {28'h0, locked, x8_o, osrc}, 32'hE);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    apb(1'b0, crsq_pkg::SYS_INTEGRITY_ADDR, 32'h0);
    chk("relock wait", rd & 32'h8, 32'h0);
    repeat (510) @(posedge clk);
    apb(1'b0, crsq_pkg::SYS_INTEGRITY_ADDR, 32'h0);
    chk("relocked", rd & 32'h8, 32'h8);
  endtask

  task automatic end_of_test;
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_run(n);
    t_regs();
    t_slow();
    t_sources();
    t_opts();
    end_of_test();
  end
endmodule
